//--- hdl/fault_host.sv
`default_nettype none
module fault_host
   import fault_mon_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // device link
   fault_mon_if.host link
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_DATA = 3'b010,
      ST_WAIT = 3'b100
   } st_type;
   st_type st_reg;
   logic wr_reg;
   logic [7:0] addr_reg;

   // address phase accepted only when idle; writes forwarded in data phase
   wire logic take = hsel && hready && htrans[1] && st_reg == ST_IDLE;

   // one device transaction per bus transfer; host by reading
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_IDLE;
         wr_reg <= 1'b0;
         addr_reg <= 8'h00;
         hreadyout <= 1'b1;
         hrdata <= 32'h0000_0000;
         link.req_valid <= 1'b0;
         link.req_write <= 1'b0;
         link.req_addr <= 8'h00;
         link.req_wdata <= 32'h0000_0000;
      end else begin
         link.req_valid <= 1'b0;
         case (st_reg)
            ST_IDLE: begin
               if (take) begin
                  wr_reg <= hwrite;
                  addr_reg <= haddr[7:0];
                  hreadyout <= 1'b0;
                  st_reg <= ST_DATA;
               end
            end
            ST_DATA: begin
               link.req_valid <= 1'b1; // on-bit writes pass here
               link.req_write <= wr_reg;
               link.req_addr <= addr_reg;
               link.req_wdata <= hwdata;
               st_reg <= ST_WAIT;
            end
            ST_WAIT: begin
               if (link.rsp_valid) begin
                  hrdata <= link.rsp_rdata;
                  hreadyout <= 1'b1;
                  st_reg <= ST_IDLE;
               end
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // response is always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hresp <= 1'b0;
      else
         hresp <= 1'b0;
   end
endmodule
`default_nettype wire

//--- hdl/fault_mon_if.sv
`default_nettype none
interface fault_mon_if;
   import fault_mon_pkg::*;
   // serial-control stand-in: one read or write per valid pulse
   logic req_valid;
   logic req_write;
   logic [7:0] req_addr;
   logic [31:0] req_wdata;
   logic rsp_valid;
   logic [31:0] rsp_rdata;
   modport dev (input req_valid, input req_write, input req_addr, input req_wdata,
                output rsp_valid, output rsp_rdata);
   modport host (output req_valid, output req_write, output req_addr, output req_wdata,
                 input rsp_valid, input rsp_rdata);
endinterface
`default_nettype wire

//--- hdl/fault_mon_pkg.sv
`default_nettype none
package fault_mon_pkg;
   localparam int NUM_CH = 5;
   localparam int CLK_MHZ = 200;
   // typical deglitch times in ns
   localparam int OTS_DGL_NS = 5000;
   localparam int SUPPLY_DGL_NS = 3500;
   localparam int CP_DGL_NS = 4000;
   localparam int OTS_DGL_CYC = OTS_DGL_NS * CLK_MHZ / 1000;
   localparam int SUPPLY_DGL_CYC = SUPPLY_DGL_NS * CLK_MHZ / 1000;
   localparam int CP_DGL_CYC = CP_DGL_NS * CLK_MHZ / 1000;
   // autorestart interval in ms
   localparam int AUTO_RESTART_MS = 64;
   localparam int AUTO_RESTART_CYC = AUTO_RESTART_MS * CLK_MHZ * 1000;
   localparam int DGL_W = 11;
   localparam int AR_W = 24;
   // register byte offsets on the host bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_QUICK = 8'h04;
   localparam logic [7:0] OFS_CH_STAT = 8'h08;
   localparam logic [7:0] OFS_DEV_STAT = 8'h1C;
   localparam logic [7:0] OFS_SENSE = 8'h20;
   // control register fields
   localparam int CTRL_ON_LSB = 0;
   localparam int CTRL_SEL_BIT = 8;
   localparam int CTRL_FAIL_BIT = 9;
   // quick status fields
   localparam int QS_WARN_LSB = 0;
   localparam int QS_SD_LSB = 8;
   localparam int QS_CPF_BIT = 16;
   localparam int DSF_BIT = 31;
   // channel status fields
   localparam int CS_WARN_BIT = 0;
   localparam int CS_SD_BIT = 1;
   // device status fields
   localparam int DS_UVF_BIT = 0;
   localparam int DS_OVF_BIT = 1;
   localparam int DS_REV_BIT = 2;
   // control register value after reset: normal mode, high warning threshold, all off
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

//--- hdl/fault_monitor.sv
// What this block does
// - warning keeps output, sets quick and channel flag
// - select bit zero high threshold, one low
// - warning clears when cool and channel read
// - shutdown after deglitch, reported after deglitch
// - normal mode restart needs clear plus on write
// - shutdown flag clears when cool and channel read
// - fail mode shutdown restarts only on mode change
// - undervoltage sets summary and undervoltage flags
// - normal mode undervoltage restart needs on write
// - undervoltage flag clears when gone and read
// - fail mode undervoltage restarts automatically
// - autorestart retried every sixty-four milliseconds
// - supply faults deglitched by 3.5 us
// - overvoltage sets summary and overvoltage flags
// - overvoltage keeps all outputs off
// - overvoltage flag clears when gone and read
// - outputs held off until pump valid, command kept
// - pump fault off after deglitch, flag set
// - commands during pump fault run when valid
// - pump flag clears when gone and quick read
// - reverse supply forces outputs on, external low
//
// Chosen here: the address map and the AHB-Lite slave port.
`default_nettype none
module fault_monitor
   import fault_mon_pkg::*;
#(
   parameter int AUTO_RESTART_CYCLES = AUTO_RESTART_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // host side
   fault_mon_if.dev bus,
   // analog comparator levels, asynchronous
   input wire logic [NUM_CH-1:0] temp_warn_hi,
   input wire logic [NUM_CH-1:0] temp_warn_lo,
   input wire logic [NUM_CH-1:0] temp_shutdown,
   input wire logic supply_under,
   input wire logic supply_over,
   input wire logic pump_valid,
   input wire logic supply_reverse,
   // power stage drive
   output logic [NUM_CH-1:0] channel_on,
   output logic external_switch_drive_output,
   output logic high_overcurrent_window_start
);
   localparam int NSYNC = 3 * NUM_CH + 4;

   // two-stage synchronisers for every analog level
   logic [NSYNC-1:0] sync1_reg, sync2_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {supply_reverse, pump_valid, supply_over, supply_under, temp_shutdown, temp_warn_lo,
                       temp_warn_hi};
         sync2_reg <= sync1_reg;
      end
   end
   wire logic [NUM_CH-1:0] warn_hi_s = sync2_reg[NUM_CH-1:0];
   wire logic [NUM_CH-1:0] warn_lo_s = sync2_reg[2*NUM_CH-1:NUM_CH];
   wire logic [NUM_CH-1:0] hot_s = sync2_reg[3*NUM_CH-1:2*NUM_CH];
   wire logic under_s = sync2_reg[3*NUM_CH];
   wire logic over_s = sync2_reg[3*NUM_CH+1];
   wire logic pump_ok_s = sync2_reg[3*NUM_CH+2];
   wire logic reverse_s = sync2_reg[3*NUM_CH+3];

   // control register
   logic [31:0] ctrl_reg;
   wire logic sel_low = ctrl_reg[CTRL_SEL_BIT];
   wire logic fail_mode = ctrl_reg[CTRL_FAIL_BIT];
   wire logic [NUM_CH-1:0] on_cmd = ctrl_reg[CTRL_ON_LSB +: NUM_CH];
   wire logic [NUM_CH-1:0] warn_now = sel_low ? warn_lo_s : warn_hi_s;

   // bus decode
   wire logic wr = bus.req_valid && bus.req_write;
   wire logic rd = bus.req_valid && !bus.req_write;
   wire logic wr_ctrl = wr && bus.req_addr == OFS_CTRL;
   wire logic rd_quick = rd && bus.req_addr == OFS_QUICK;
   wire logic rd_dev = rd && bus.req_addr == OFS_DEV_STAT;
   wire logic mode_change = wr_ctrl && (bus.req_wdata[CTRL_FAIL_BIT] != fail_mode);
   logic [NUM_CH-1:0] rd_ch;

   // deglitch filter for one level; qualified output
   function automatic logic [DGL_W-1:0] dgl_step(input logic lvl, input logic [DGL_W-1:0] cnt);
      return lvl ? ((cnt == '1) ? cnt : cnt + 1'b1) : '0;
   endfunction

   logic [DGL_W-1:0] uv_cnt_reg, ov_cnt_reg, cp_cnt_reg;
   logic [NUM_CH-1:0][DGL_W-1:0] ots_cnt_reg;
   wire logic uv_q = uv_cnt_reg >= DGL_W'(SUPPLY_DGL_CYC);
   wire logic ov_q = ov_cnt_reg >= DGL_W'(SUPPLY_DGL_CYC);
   wire logic cp_q = cp_cnt_reg >= DGL_W'(CP_DGL_CYC);
   logic [NUM_CH-1:0] ots_q;

   // latched flags
   logic [NUM_CH-1:0] warn_flag_reg, sd_flag_reg, sd_off_reg, ar_pend_reg;
   logic uvf_reg, ovf_reg, cpf_reg, uv_off_reg;
   logic [AR_W-1:0] ar_cnt_reg;
   wire logic ar_tick = ar_cnt_reg >= AR_W'(AUTO_RESTART_CYCLES - 1);
   // raw pump level only holds outputs before it first settles; later losses wait for the deglitch
   logic pump_seen_reg;
   wire logic pump_settling = !pump_ok_s && !pump_seen_reg;
   wire logic supply_bad = uv_q || ov_q || pump_settling;

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         assign rd_ch[g] = rd && bus.req_addr == OFS_CH_STAT + 8'(4 * g);
         assign ots_q[g] = ots_cnt_reg[g] >= DGL_W'(OTS_DGL_CYC);
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ots_cnt_reg[g] <= '0;
               warn_flag_reg[g] <= 1'b0;
               sd_flag_reg[g] <= 1'b0;
               sd_off_reg[g] <= 1'b0;
            end else begin
               ots_cnt_reg[g] <= dgl_step(hot_s[g], ots_cnt_reg[g]);
               // set wins over read-clear
               warn_flag_reg[g] <= warn_now[g] | (warn_flag_reg[g] & ~rd_ch[g]);
               sd_flag_reg[g] <= ots_q[g] | (sd_flag_reg[g] & ~rd_ch[g]);
               if (ots_q[g])
                  sd_off_reg[g] <= 1'b1;
               else if (fail_mode ? mode_change : (wr_ctrl && bus.req_wdata[CTRL_ON_LSB + g]))
                  sd_off_reg[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // supply, pump and autorestart state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uv_cnt_reg <= '0;
         ov_cnt_reg <= '0;
         cp_cnt_reg <= '0;
         uvf_reg <= 1'b0;
         ovf_reg <= 1'b0;
         cpf_reg <= 1'b0;
         uv_off_reg <= 1'b0;
         ar_cnt_reg <= '0;
         ar_pend_reg <= '0;
         pump_seen_reg <= 1'b0;
      end else begin
         uv_cnt_reg <= dgl_step(under_s, uv_cnt_reg);
         ov_cnt_reg <= dgl_step(over_s, ov_cnt_reg);
         cp_cnt_reg <= dgl_step(!pump_ok_s, cp_cnt_reg);
         uvf_reg <= uv_q | (uvf_reg & ~rd_dev);
         ovf_reg <= ov_q | (ovf_reg & ~rd_dev);
         cpf_reg <= cp_q | (cpf_reg & ~rd_quick);
         // undervoltage shutdown latched until restart action
         if (uv_q)
            uv_off_reg <= 1'b1;
         else if (!fail_mode && wr_ctrl && (bus.req_wdata[CTRL_ON_LSB +: NUM_CH] != '0))
            uv_off_reg <= 1'b0;
         else if (fail_mode && ar_tick)
            uv_off_reg <= 1'b0;
         // autorestart timer runs only while a latched off is waiting in fail mode
         if (fail_mode && uv_off_reg && !uv_q)
            ar_cnt_reg <= ar_tick ? '0 : ar_cnt_reg + 1'b1;
         else
            ar_cnt_reg <= '0;
         ar_pend_reg <= on_cmd & ~channel_on;
         pump_seen_reg <= pump_seen_reg | pump_ok_s;
      end
   end

   // output drive: commands held in ctrl_reg run once pump is valid
   wire logic [NUM_CH-1:0] run_on = on_cmd & ~sd_off_reg & {NUM_CH{!uv_off_reg && !supply_bad && !cp_q}};
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         channel_on <= '0;
         external_switch_drive_output <= 1'b0;
         high_overcurrent_window_start <= 1'b0;
      end else if (reverse_s) begin
         channel_on <= '1;
         external_switch_drive_output <= 1'b0;
         high_overcurrent_window_start <= 1'b0;
      end else begin
         channel_on <= run_on;
         external_switch_drive_output <= 1'b0;
         // only the first cycle of a held command turning on, so the pulse is one cycle wide
         high_overcurrent_window_start <= |(run_on & ~channel_on & ar_pend_reg);
      end
   end

   // register file and read answer; answer one cycle after request
   wire logic device_status_summary_flag = uvf_reg | ovf_reg | cpf_reg;
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (bus.req_addr)
         OFS_CTRL: rd_mux = ctrl_reg;
         OFS_QUICK: begin
            rd_mux[QS_WARN_LSB +: NUM_CH] = warn_flag_reg;
            rd_mux[QS_SD_LSB +: NUM_CH] = sd_flag_reg;
            rd_mux[QS_CPF_BIT] = cpf_reg;
         end
         OFS_DEV_STAT: begin
            rd_mux[DS_UVF_BIT] = uvf_reg;
            rd_mux[DS_OVF_BIT] = ovf_reg;
            rd_mux[DS_REV_BIT] = reverse_s;
         end
         OFS_SENSE: rd_mux[NUM_CH-1:0] = channel_on;
         default: begin
            for (int i = 0; i < NUM_CH; i++) begin
               if (bus.req_addr == OFS_CH_STAT + 8'(4 * i)) begin
                  rd_mux[CS_WARN_BIT] = warn_flag_reg[i];
                  rd_mux[CS_SD_BIT] = sd_flag_reg[i];
               end
            end
         end
      endcase
      if (bus.req_addr != OFS_CTRL && bus.req_addr != OFS_SENSE)
         rd_mux[DSF_BIT] = device_status_summary_flag;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         bus.rsp_valid <= 1'b0;
         bus.rsp_rdata <= 32'h0000_0000;
      end else begin
         if (wr_ctrl)
            ctrl_reg <= bus.req_wdata;
         bus.rsp_valid <= bus.req_valid;
         bus.rsp_rdata <= rd ? rd_mux : 32'h0000_0000;
      end
   end
endmodule
`default_nettype wire

//--- test/fault_mon_asserts.sv
`default_nettype none
module fault_mon_asserts
   import fault_mon_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // link handshake
   input wire logic req_valid,
   input wire logic rsp_valid,
   // device pins
   input wire logic [NUM_CH-1:0] temp_shutdown,
   input wire logic supply_under,
   input wire logic supply_over,
   input wire logic pump_valid,
   input wire logic supply_reverse,
   input wire logic [NUM_CH-1:0] channel_on,
   input wire logic external_switch_drive_output
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] uv_cnt;
   logic [10:0] ov_cnt;
   logic [10:0] cp_cnt;
   logic [10:0] sd_cnt;
   logic [NUM_CH-1:0] sd_last;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // run length of each fault; saturating so a long fault never wraps to zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {uv_cnt, ov_cnt, cp_cnt, sd_cnt} <= '0;
         sd_last <= '0;
      end else begin
         uv_cnt <= supply_under ? uv_cnt + 11'(uv_cnt != '1) : '0;
         ov_cnt <= supply_over ? ov_cnt + 11'(ov_cnt != '1) : '0;
         cp_cnt <= !pump_valid ? cp_cnt + 11'(cp_cnt != '1) : '0;
         // a change of the hot pattern restarts the run, though the design's own filter counts each channel on its own
         sd_cnt <= (|temp_shutdown && temp_shutdown == sd_last) ? sd_cnt + 11'(sd_cnt != '1) : '0;
         sd_last <= temp_shutdown;
      end
   end
   chk_rsp_after_req: // link answer
      assert property (req_valid |=> rsp_valid) else $error("no answer one cycle after request");
   chk_rsp_has_cause: // link answer
      assert property (rsp_valid |-> $past(req_valid)) else $error("answer without request");
   chk_req_one_pulse: // link request
      assert property (req_valid |=> !req_valid) else $error("request wider than one cycle");
   chk_uv_all_off:
      assert property (uv_cnt > 11'd710 && !supply_reverse |-> channel_on == '0) else $error("output on in undervoltage");
   chk_ov_all_off:
      assert property (ov_cnt > 11'd710 && !supply_reverse |-> channel_on == '0) else $error("output on in overvoltage");
   chk_pump_all_off:
      assert property (cp_cnt > 11'd810 && !supply_reverse |-> channel_on == '0) else $error("output on in pump fault");
   chk_shutdown_off:
      assert property (sd_cnt > 11'd1010 && !supply_reverse |-> (channel_on & temp_shutdown) == '0)
         else $error("hot channel still on");
   chk_reverse_on:
      assert property (supply_reverse [*4] |-> channel_on == '1) else $error("reverse supply left channel off");
   chk_ext_low:
      assert property (external_switch_drive_output == 1'b0) else $error("external drive not low");
   cover property (uv_cnt == 11'd720);
   cover property (sd_cnt == 11'd1020);
   cover property (supply_reverse [*4]);
endmodule
`default_nettype wire

//--- test/testbench.sv
`default_nettype none
module testbench
   import fault_mon_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hreadyout, hresp, ext_drive, win_start;
   int win_count = 0;
   int win_base = 0;
   logic supply_under, supply_over, pump_valid, supply_reverse;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [NUM_CH-1:0] temp_warn_hi, temp_warn_lo, temp_shutdown, channel_on;
   int err_total = 0;
   int check_count = 0;
   int cycles = 0;
   fault_mon_if link_if ();
   fault_host u_fault_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link(link_if.host));
   // short restart interval keeps the fail-mode runs brief
   fault_monitor #(.AUTO_RESTART_CYCLES(200)) u_fault_monitor (.hclk(hclk), .hresetn(hresetn),
      .bus(link_if.dev), .temp_warn_hi(temp_warn_hi), .temp_warn_lo(temp_warn_lo), .temp_shutdown(temp_shutdown),
      .supply_under(supply_under), .supply_over(supply_over), .pump_valid(pump_valid),
      .supply_reverse(supply_reverse), .channel_on(channel_on), .external_switch_drive_output(ext_drive),
      .high_overcurrent_window_start(win_start));
   fault_mon_asserts u_fault_mon_asserts (.hclk(hclk), .hresetn(hresetn), .req_valid(link_if.req_valid),
      .rsp_valid(link_if.rsp_valid), .temp_shutdown(temp_shutdown), .supply_under(supply_under),
      .supply_over(supply_over), .pump_valid(pump_valid), .supply_reverse(supply_reverse),
      .channel_on(channel_on), .external_switch_drive_output(ext_drive));
   initial forever #2.5 hclk = ~hclk;
   // cycle ceiling and a count of the one-cycle window pulses
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (win_start === 1'b1) win_count <= win_count + 1;
      if (cycles == 60000) begin
         err_total++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // one single AHB word; waits on hready, no fixed latency assumed
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      {hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask
   task automatic rbit(input logic [7:0] a, input int b, input logic e);
      xfer(1'b0, a, 32'h0);
      check({31'h0, rd[b]}, {31'h0, e});
   endtask
   task automatic on_chk(input logic [NUM_CH-1:0] e);
      check(32'(channel_on), 32'(e));
   endtask
   initial begin
      {hresetn, hsel, htrans, hwrite, haddr, hwdata, hsize} = {1'b0, 1'b0, 2'b00, 1'b0, 64'h0, 3'b010};
      {temp_warn_hi, temp_warn_lo, temp_shutdown} = '0;
      {supply_under, supply_over, pump_valid, supply_reverse} = '0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      // reset state, an unmapped word, then power-up with the pump not yet settled
      xfer(1'b0, OFS_CTRL, 32'h0);
      check(rd, CTRL_RESET);
      xfer(1'b0, 8'h40, 32'h0);
      check(rd, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h1F);
      on_chk(5'h00);
      pump_valid <= 1'b1;
      repeat (6) @(posedge hclk);
      on_chk(5'h1F);
      check(32'(win_count - win_base), 32'h1);
      // pump fault with a command issued meanwhile; outputs stay on inside the deglitch
      win_base = win_count;
      pump_valid <= 1'b0;
      repeat (500) @(posedge hclk);
      on_chk(5'h1F);
      repeat (400) @(posedge hclk);
      on_chk(5'h00);
      xfer(1'b1, OFS_CTRL, 32'h1F);
      rbit(OFS_QUICK, QS_CPF_BIT, 1'b1);
      rbit(OFS_QUICK, DSF_BIT, 1'b1);
      pump_valid <= 1'b1;
      repeat (6) @(posedge hclk);
      on_chk(5'h1F);
      check(32'(win_count - win_base), 32'h1);
      rbit(OFS_QUICK, QS_CPF_BIT, 1'b1);
      rbit(OFS_QUICK, QS_CPF_BIT, 1'b0);
      $display("test pump done");
      // warning on channel 1, then the threshold select
      temp_warn_hi <= 5'h02;
      repeat (4) @(posedge hclk);
      rbit(OFS_QUICK, QS_WARN_LSB + 1, 1'b1);
      on_chk(5'h1F);
      rbit(OFS_CH_STAT + 8'h04, CS_WARN_BIT, 1'b1);
      temp_warn_hi <= 5'h00;
      repeat (4) @(posedge hclk);
      rbit(OFS_CH_STAT + 8'h04, CS_WARN_BIT, 1'b1);
      rbit(OFS_CH_STAT + 8'h04, CS_WARN_BIT, 1'b0);
      temp_warn_lo <= 5'h04;
      repeat (4) @(posedge hclk);
      rbit(OFS_QUICK, QS_WARN_LSB + 2, 1'b0);
      xfer(1'b1, OFS_CTRL, 32'h11F);
      rbit(OFS_QUICK, QS_WARN_LSB + 2, 1'b1);
      temp_warn_lo <= 5'h00;
      $display("test warning done");
      // shutdown on channel 3 in normal mode
      temp_shutdown <= 5'h08;
      repeat (500) @(posedge hclk);
      on_chk(5'h1F);
      rbit(OFS_QUICK, QS_SD_LSB + 3, 1'b0);
      repeat (600) @(posedge hclk);
      on_chk(5'h17);
      rbit(OFS_QUICK, QS_SD_LSB + 3, 1'b1);
      temp_shutdown <= 5'h00;
      repeat (10) @(posedge hclk);
      on_chk(5'h17);
      rbit(OFS_CH_STAT + 8'h0C, CS_SD_BIT, 1'b1);
      rbit(OFS_CH_STAT + 8'h0C, CS_SD_BIT, 1'b0);
      xfer(1'b1, OFS_CTRL, 32'h11F);
      repeat (4) @(posedge hclk);
      on_chk(5'h1F);
      $display("test shutdown done");
      // supply faults in normal mode: pass 0 undervoltage, pass 1 overvoltage
      for (int i = 0; i < 2; i++) begin
         {supply_over, supply_under} <= 2'(2'b01 << i);
         repeat (600) @(posedge hclk);
         on_chk(5'h1F);
         repeat (200) @(posedge hclk);
         on_chk(5'h00);
         rbit(OFS_DEV_STAT, i, 1'b1);
         rbit(OFS_CH_STAT, DSF_BIT, 1'b1);
         {supply_over, supply_under} <= 2'b00;
         repeat (10) @(posedge hclk);
         rbit(OFS_DEV_STAT, i, 1'b1);
         rbit(OFS_DEV_STAT, i, 1'b0);
         if (i == 0) on_chk(5'h00);
         xfer(1'b1, OFS_CTRL, 32'h11F);
         repeat (4) @(posedge hclk);
         on_chk(5'h1F);
         $display("test supply pass %0d done", i);
      end
      // fail mode: undervoltage restarts alone, shutdown waits for a mode change
      xfer(1'b1, OFS_CTRL, 32'h31F);
      supply_under <= 1'b1;
      repeat (800) @(posedge hclk);
      on_chk(5'h00);
      supply_under <= 1'b0;
      repeat (100) @(posedge hclk);
      on_chk(5'h00);
      repeat (1100) @(posedge hclk);
      on_chk(5'h1F);
      temp_shutdown <= 5'h10;
      repeat (1100) @(posedge hclk);
      temp_shutdown <= 5'h00;
      repeat (400) @(posedge hclk);
      on_chk(5'h0F);
      xfer(1'b1, OFS_CTRL, 32'h31F);
      repeat (4) @(posedge hclk);
      on_chk(5'h0F);
      xfer(1'b1, OFS_CTRL, 32'h11F);
      repeat (4) @(posedge hclk);
      on_chk(5'h1F);
      $display("test fail mode done");
      // reverse supply overrides a host off command
      xfer(1'b1, OFS_CTRL, 32'h0);
      supply_reverse <= 1'b1;
      repeat (5) @(posedge hclk);
      on_chk(5'h1F);
      check({31'h0, ext_drive}, 32'h0);
      rbit(OFS_DEV_STAT, DS_REV_BIT, 1'b1);
      supply_reverse <= 1'b0;
      $display("test reverse done");
      end_sim();
   end
endmodule
`default_nettype wire
